/* File: rtl/hub_port_pin_strap_mux.sv */
// Pin sharing, strap capture and EEPROM pin routing for hub ports 0 and 1
`timescale 1ns/1ps
`default_nettype none
module hub_port_pin_strap_mux
  import pin_strap_pkg::*;
#(
  parameter int HOLD_CYC = STRAP_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       nrst_i,
  // Shared indicator pins: [0] amber, [1] green per port
  input  wire logic [pin_strap_pkg::NPORT-1:0][1:0] led_pin_i,
  output logic      [pin_strap_pkg::NPORT-1:0][1:0] led_pin_o,
  output logic      [pin_strap_pkg::NPORT-1:0][1:0] led_pin_oe_o,
  // Dedicated non-removable straps (only bit 0 is sampled; port 1 uses its green LED pin) and test-select pin
  input  wire logic [pin_strap_pkg::NPORT-1:0]      nonremovable_strap_i,
  input  wire logic                       test_sel_pin_i,
  output logic                            test_sel_pin_o,
  output logic                            test_sel_pin_oe_o,
  // Port power and overcurrent
  input  wire logic [pin_strap_pkg::NPORT-1:0]      port_overcurrent_n_i,
  input  wire logic                       port_power_enable_n_i,
  output logic      [pin_strap_pkg::NPORT-1:0]      port_power_enable_n_o,
  output logic      [pin_strap_pkg::NPORT-1:0]      port_power_enable_n_oe_o,
  // Core side controls
  input  wire logic [pin_strap_pkg::NPORT-1:0]      port_power_on_i,
  input  wire logic [pin_strap_pkg::NPORT-1:0]      port_power_float_i,
  input  wire logic [pin_strap_pkg::NPORT-1:0][1:0] led_on_i,
  input  wire logic                       eeprom_req_i,
  input  wire logic                       eeprom_done_i,
  input  wire logic                       eeprom_use_i2c_i,
  input  wire pin_strap_pkg::spi_s        spi_i,
  input  wire logic                       i2c_scl_low_i,
  input  wire logic                       i2c_sda_low_i,
  // Core side status
  output pin_strap_pkg::strap_s           strap_o,
  output logic                            straps_valid_o,
  output logic                            eeprom_phase_o,
  output logic                            spi_miso_o,
  output logic                            i2c_sda_o,
  output logic [pin_strap_pkg::NPORT-1:0]           overcurrent_o
);
  import pin_strap_pkg::*;

  // Three-stage synchronisers; stage 0 feeds only stage 1
  logic [2:0][NPORT-1:0][1:0] led_sync_reg,  led_sync_next;
  logic [2:0][NPORT-1:0]      nr_sync_reg,   nr_sync_next;
  logic [2:0][NPORT-1:0]      ovr_sync_reg,  ovr_sync_next;
  logic [2:0]                 tst_sync_reg,  tst_sync_next;
  logic [2:0]                 sda_sync_reg,  sda_sync_next;

  always_comb begin
    led_sync_next = {led_sync_reg[1:0], led_pin_i};
    nr_sync_next  = {nr_sync_reg[1:0], nonremovable_strap_i};
    ovr_sync_next = {ovr_sync_reg[1:0], port_overcurrent_n_i};
    tst_sync_next = {tst_sync_reg[1:0], test_sel_pin_i};
    sda_sync_next = {sda_sync_reg[1:0], port_power_enable_n_i};
  end

  always_ff @(posedge mclk_i) begin
    led_sync_reg <= led_sync_next;
    nr_sync_reg  <= nr_sync_next;
    ovr_sync_reg <= ovr_sync_next;
    tst_sync_reg <= tst_sync_next;
    sda_sync_reg <= sda_sync_next;
  end

  // Overcurrent filter, one copy per port
  logic [NPORT-1:0] ovr_reg, ovr_next;

  for (genvar gp = 0; gp < NPORT; gp++) begin : g_ovr
    always_comb begin
      ovr_next[gp] = ovr_reg[gp];
      // Glitch guard: change accepted only when stages 1 and 2 agree
      if (ovr_sync_reg[1][gp] == ovr_sync_reg[2][gp]) begin
        ovr_next[gp] = ~ovr_sync_reg[2][gp];
      end
    end

    always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
        ovr_reg[gp] <= 1'b0;
      end else begin
        ovr_reg[gp] <= ovr_next[gp];
      end
    end
  end

  // Phase sequencer and strap capture
  phase_e      phase_reg, phase_next;
  logic [31:0] cnt_reg,   cnt_next;
  strap_s      strap_reg, strap_next;
  logic        settle_reg, settle_next;
  logic        valid_reg,  valid_next;
  logic        ephase_reg, ephase_next;

  always_comb begin
    phase_next  = phase_reg;
    cnt_next    = cnt_reg;
    strap_next  = strap_reg;
    settle_next = settle_reg;
    case (phase_reg)
      PH_STRAP: begin
        // Wait for synchroniser to fill before sampling
        if (settle_reg) begin
          strap_next.test_mode       = tst_sync_reg[2];
          strap_next.switch_pol      = led_sync_reg[2][1][POS_AMBER];
          strap_next.nonremovable[0] = nr_sync_reg[2][0];
          strap_next.nonremovable[1] = led_sync_reg[2][1][POS_GREEN];
          phase_next = PH_HOLD;
        end
        settle_next = cnt_reg >= 32'd3;
        cnt_next    = cnt_reg + 32'd1;
        if (settle_reg) begin
          cnt_next = 32'd0;
        end
      end
      PH_HOLD: begin
        // Strapped-high pins need their pull released before LED drive
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg >= 32'(HOLD_CYC - 1)) begin
          phase_next = eeprom_req_i ? PH_EEPROM : PH_RUN;
        end
      end
      PH_EEPROM: begin
        if (eeprom_done_i) begin
          phase_next = PH_RUN;
        end
      end
      default: begin
        phase_next = PH_RUN;
      end
    endcase
    // Status flags registered so the outputs come straight from flops
    valid_next  = (phase_next != PH_STRAP);
    ephase_next = (phase_next == PH_EEPROM);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      phase_reg  <= PH_STRAP;
      cnt_reg    <= 32'd0;
      strap_reg  <= '{RST_STRAP, RST_STRAP, {NPORT{RST_STRAP}}};
      settle_reg <= 1'b0;
      valid_reg  <= 1'b0;
      ephase_reg <= 1'b0;
    end else begin
      phase_reg  <= phase_next;
      cnt_reg    <= cnt_next;
      strap_reg  <= strap_next;
      settle_reg <= settle_next;
      valid_reg  <= valid_next;
      ephase_reg <= ephase_next;
    end
  end

  // Pin drivers, all registered
  logic [NPORT-1:0][1:0] led_o_next, led_oe_next;
  logic [NPORT-1:0]      pwr_next,   pwr_oe_next;
  logic                  tst_o_next, tst_oe_next, miso_next, sda_next;
  logic                  spi_mode, i2c_mode;

  always_comb begin
    spi_mode    = (phase_reg == PH_EEPROM) && !eeprom_use_i2c_i;
    i2c_mode    = (phase_reg == PH_EEPROM) && eeprom_use_i2c_i;
    led_o_next  = '0;
    led_oe_next = '0;
    pwr_next    = '0;
    pwr_oe_next = '0;
    tst_o_next  = 1'b0;
    tst_oe_next = 1'b0;
    miso_next   = spi_mode ? led_sync_reg[2][1][POS_GREEN] : 1'b0;
    sda_next    = i2c_mode ? sda_sync_reg[2] : 1'b1;
    if (phase_reg == PH_RUN) begin
      led_o_next  = led_on_i;
      led_oe_next = {NPORT{2'b11}};
      for (int p = 0; p < NPORT; p++) begin
        // Polarity strap high flips enable to active high
        pwr_next[p]    = port_power_on_i[p] ~^ strap_reg.switch_pol;
        pwr_oe_next[p] = !port_power_float_i[p];
      end
    end else if (spi_mode) begin
      led_o_next[0][POS_AMBER]  = spi_i.cs;
      led_o_next[0][POS_GREEN]  = spi_i.sck;
      led_o_next[1][POS_AMBER]  = spi_i.mosi;
      led_oe_next[0]            = 2'b11;
      led_oe_next[1][POS_AMBER] = 1'b1;
    end else if (i2c_mode) begin
      // Open drain: drive only low
      tst_oe_next    = i2c_scl_low_i;
      pwr_oe_next[0] = i2c_sda_low_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      led_pin_o                <= '0;
      led_pin_oe_o             <= '0;
      port_power_enable_n_o    <= '0;
      port_power_enable_n_oe_o <= '0;
      test_sel_pin_o           <= 1'b0;
      test_sel_pin_oe_o        <= 1'b0;
      spi_miso_o               <= 1'b0;
      i2c_sda_o                <= 1'b1;
    end else begin
      led_pin_o                <= led_o_next;
      led_pin_oe_o             <= led_oe_next;
      port_power_enable_n_o    <= pwr_next;
      port_power_enable_n_oe_o <= pwr_oe_next;
      test_sel_pin_o           <= tst_o_next;
      test_sel_pin_oe_o        <= tst_oe_next;
      spi_miso_o               <= miso_next;
      i2c_sda_o                <= sda_next;
    end
  end

  assign strap_o        = strap_reg;
  assign straps_valid_o = valid_reg;
  assign eeprom_phase_o = ephase_reg;
  assign overcurrent_o  = ovr_reg;

  // Checks
  property p_no_led_before_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg != PH_RUN) |=> (led_pin_oe_o == '0 || $past(spi_mode));
  endproperty
  a_no_led_before_hold: assert property (p_no_led_before_hold) else $error("LED driven before hold end");

  property p_led_high_on;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg == PH_RUN && led_on_i[0][0]) |=> led_pin_o[0][0];
  endproperty
  a_led_high_on: assert property (p_led_high_on) else $error("LED not driven high");

  property p_pwr_low_default;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg == PH_RUN && !strap_reg.switch_pol && port_power_on_i[1]) |=> !port_power_enable_n_o[1];
  endproperty
  a_pwr_low_default: assert property (p_pwr_low_default) else $error("Power enable not low");

  property p_pol_flip;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg == PH_RUN && strap_reg.switch_pol && port_power_on_i[0]) |=> port_power_enable_n_o[0];
  endproperty
  a_pol_flip: assert property (p_pol_flip) else $error("Polarity not applied");

  sequence s_ovr_low_steady;
    !ovr_sync_reg[1][0] && !ovr_sync_reg[2][0];
  endsequence
  property p_ovr_flag;
    @(posedge mclk_i) disable iff (!nrst_i) s_ovr_low_steady |=> overcurrent_o[0];
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("Overcurrent missed");

  property p_strap_stable;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg == PH_RUN) |=> $stable(strap_reg);
  endproperty
  a_strap_stable: assert property (p_strap_stable) else $error("Strap changed after capture");

  property p_spi_cs;
    @(posedge mclk_i) disable iff (!nrst_i) spi_mode |=> led_pin_o[0][0] == $past(spi_i.cs);
  endproperty
  a_spi_cs: assert property (p_spi_cs) else $error("SPI select not routed");

  property p_i2c_od;
    @(posedge mclk_i) disable iff (!nrst_i) (i2c_mode && i2c_scl_low_i) |=> (test_sel_pin_oe_o && !test_sel_pin_o);
  endproperty
  a_i2c_od: assert property (p_i2c_od) else $error("I2C clock driven high");

  property p_eeprom_before_run;
    @(posedge mclk_i) disable iff (!nrst_i)
      (phase_reg == PH_EEPROM && !eeprom_done_i) |=> phase_reg == PH_EEPROM;
  endproperty
  a_eeprom_before_run: assert property (p_eeprom_before_run) else $error("Left EEPROM phase early");
endmodule : hub_port_pin_strap_mux
`default_nettype wire

/* File: rtl/pin_strap_pkg.sv */
// Package: constants, phases and carriers for the hub pin strap mux
package pin_strap_pkg;
  localparam int  CLK_HZ          = 20_000_000;
  localparam int  STRAP_HOLD_MS   = 60;
  localparam int  STRAP_HOLD_CYC  = (CLK_HZ / 1000) * STRAP_HOLD_MS;
  localparam int  NPORT           = 2;
  localparam int  POS_AMBER       = 0;
  localparam int  POS_GREEN       = 1;
  localparam logic RST_STRAP      = 1'b0;
  localparam logic RST_LED        = 1'b0;

  typedef enum logic [1:0] {
    PH_STRAP  = 2'b00,
    PH_HOLD   = 2'b01,
    PH_EEPROM = 2'b10,
    PH_RUN    = 2'b11
  } phase_e;

  typedef struct packed {
    logic       test_mode;
    logic       switch_pol;
    logic [1:0] nonremovable;
  } strap_s;

  typedef struct packed {
    logic cs;
    logic sck;
    logic mosi;
  } spi_s;
endpackage : pin_strap_pkg

/* File: test/pin_partner_model.sv */
// Far-side pin model: strap resistors, SPI EEPROM data in, I2C data line
`timescale 1ns/1ps
`default_nettype none
module pin_partner_model (
  // Device pin drive
  input  wire logic [3:0] led_i,
  input  wire logic [3:0] led_oe_i,
  input  wire logic       sda_i,
  input  wire logic       sda_oe_i,
  // Far-side drivers
  input  wire logic [3:0] ext_en_i,
  input  wire logic [3:0] ext_val_i,
  input  wire logic       sda_low_i,
  // Resolved pin levels
  output logic      [3:0] led_lvl_o,
  output logic            sda_lvl_o
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // Released pins fall to the pull-down, never keep the last value
      led_lvl_o[i] = led_oe_i[i] ? led_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b0);
    end
    sda_lvl_o = !(sda_oe_i && !sda_i) && !sda_low_i;
  end
endmodule : pin_partner_model
`default_nettype wire

/* File: test/hub_port_pin_strap_mux_test.sv */
// Self-checking bench for the hub pin strap mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module hub_port_pin_strap_mux_test;
  import pin_strap_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] led_lvl, led_o, led_oe, led_on, ext_en, ext_val;
  logic [1:0] nrs, ocn, pwr_o, pwr_oe, pon, pfl, oc;
  logic tsel, tsel_o, tsel_oe, pwr_lvl, ereq, edone, ei2c, scl_low, sda_low, dev_low;
  logic svalid, ephase, miso, sda;
  spi_s spi;
  strap_s strap;
  int num_errors = 0;
  int tests_run = 0;

  always #25 mclk_i = ~mclk_i;

  hub_port_pin_strap_mux #(.HOLD_CYC(20)) u_dut (
    .mclk_i(mclk_i), .nrst_i(nrst), .led_pin_i(led_lvl), .led_pin_o(led_o), .led_pin_oe_o(led_oe),
    .nonremovable_strap_i(nrs), .test_sel_pin_i(tsel && !tsel_oe), .test_sel_pin_o(tsel_o),
    .test_sel_pin_oe_o(tsel_oe), .port_overcurrent_n_i(ocn), .port_power_enable_n_i(pwr_lvl),
    .port_power_enable_n_o(pwr_o), .port_power_enable_n_oe_o(pwr_oe), .port_power_on_i(pon),
    .port_power_float_i(pfl), .led_on_i(led_on), .eeprom_req_i(ereq), .eeprom_done_i(edone),
    .eeprom_use_i2c_i(ei2c), .spi_i(spi), .i2c_scl_low_i(scl_low), .i2c_sda_low_i(sda_low),
    .strap_o(strap), .straps_valid_o(svalid), .eeprom_phase_o(ephase), .spi_miso_o(miso),
    .i2c_sda_o(sda), .overcurrent_o(oc));

  pin_partner_model u_far (
    .led_i(led_o), .led_oe_i(led_oe), .sda_i(pwr_o[0]), .sda_oe_i(pwr_oe[0]), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .sda_low_i(dev_low), .led_lvl_o(led_lvl), .sda_lvl_o(pwr_lvl));

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Straps held by the far side until valid, then released inside the hold
  task automatic do_reset(input logic pol, input logic fix2, input logic tst, input logic req, input logic i2c);
    nrst = 1'b0;
    ext_en = 4'b1100;
    ext_val = {fix2, pol, 2'b00};
    tsel = tst;
    ereq = req;
    ei2c = i2c;
    tick(20);
    nrst = 1'b1;
    for (int i = 0; i < 20 && svalid !== 1'b1; i++) tick(1);
    `CHK(svalid, 1'b1)
    ext_en = 4'b0000;
    tick(1);
    `CHK(led_oe, 4'b0000)
    `CHK(pwr_oe, 2'b00)
  endtask : do_reset

  task automatic wait_run;
    for (int i = 0; i < 40 && led_oe !== 4'hf; i++) tick(1);
    `CHK(led_oe, 4'hf)
  endtask : wait_run

  task automatic run_straps_leds_power;
    nrs = 2'b01;
    do_reset(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    `CHK(strap, 4'b0111)
    wait_run();
    `CHK(ephase, 1'b0)
    led_on = 4'b1001;
    pon = 2'b01;
    pfl = 2'b00;
    tick(2);
    `CHK(led_o, 4'b1001)
    `CHK(pwr_o, 2'b01)
    `CHK(pwr_oe, 2'b11)
    pfl = 2'b10;
    tick(2);
    `CHK(pwr_oe, 2'b01)
    ocn = 2'b10;
    tick(8);
    `CHK(oc, 2'b01)
    ocn = 2'b01;
    tick(8);
    `CHK(oc, 2'b10)
    ocn = 2'b11;
    tick(8);
    `CHK(oc, 2'b00)
  endtask : run_straps_leds_power

  task automatic spi_then_run;
    nrs = 2'b00;
    do_reset(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    `CHK(strap, 4'b1000)
    for (int i = 0; i < 40 && ephase !== 1'b1; i++) tick(1);
    `CHK(ephase, 1'b1)
    spi = 3'b101;
    ext_en = 4'b1000;
    ext_val = 4'b1000;
    tick(2);
    `CHK(led_oe, 4'b0111)
    `CHK(led_o[2:0], 3'b101)
    spi = 3'b010;
    tick(6);
    `CHK(led_o[2:0], 3'b010)
    `CHK(miso, 1'b1)
    ext_val = 4'b0000;
    tick(6);
    `CHK(miso, 1'b0)
    ext_en = 4'b0000;
    edone = 1'b1;
    wait_run();
    edone = 1'b0;
    pon = 2'b10;
    pfl = 2'b00;
    tick(2);
    `CHK(pwr_o, 2'b01)
  endtask : spi_then_run

  task automatic i2c_lines;
    do_reset(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 40 && ephase !== 1'b1; i++) tick(1);
    `CHK(ephase, 1'b1)
    scl_low = 1'b1;
    tick(2);
    `CHK({tsel_oe, tsel_o}, 2'b10)
    scl_low = 1'b0;
    sda_low = 1'b1;
    tick(6);
    `CHK({tsel_oe, pwr_oe[0], sda}, 3'b010)
    sda_low = 1'b0;
    tick(6);
    `CHK(sda, 1'b1)
    dev_low = 1'b1;
    tick(6);
    `CHK(sda, 1'b0)
    dev_low = 1'b0;
    edone = 1'b1;
    wait_run();
  endtask : i2c_lines

  initial begin
    {nrs, ocn, pon, pfl, led_on} = {2'b00, 2'b11, 2'b11, 2'b00, 4'hf};
    {tsel, ereq, edone, ei2c, scl_low, sda_low, dev_low} = 7'h00;
    {ext_en, ext_val, spi} = 11'h000;
    tick(1);
    run_straps_leds_power();
    spi_then_run();
    i2c_lines();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge mclk_i);
    num_errors++;
    final_report();
  end
endmodule : hub_port_pin_strap_mux_test
`default_nettype wire
